// ### logic/fevro_regs.svh
// Purpose: Offsets, fields and constants of the erase-verify/read-once
//          flash sequencer.
// Assumes: Byte-wide registers, one per aligned 32-bit Avalon word.
// Notes:   Byte address is four times the register index.
`ifndef FEVRO_REGS_SVH
`define FEVRO_REGS_SVH
// Register indices
`define FEVRO_IDX_STAT      10'h006
`define FEVRO_IDX_COMMAND_OBJECT_INDEX    10'h002
`define FEVRO_IDX_CCOB0_HI  10'h00c
`define FEVRO_IDX_CCOB0_LO  10'h00d
`define FEVRO_IDX_CCOB1_HI  10'h00e
`define FEVRO_IDX_CCOB1_LO  10'h00f
`define FEVRO_IDX_CCOB2_HI  10'h010
`define FEVRO_IDX_CCOB2_LO  10'h011
`define FEVRO_IDX_CCOB3_HI  10'h012
`define FEVRO_IDX_CCOB3_LO  10'h013
`define FEVRO_IDX_CCOB4_HI  10'h014
`define FEVRO_IDX_CCOB4_LO  10'h015
`define FEVRO_IDX_CCOB5_HI  10'h396
`define FEVRO_IDX_CCOB5_LO  10'h397
`define FEVRO_IDX_IRQ_STAT  10'h020
`define FEVRO_IDX_IRQ_MASK  10'h021
`define FEVRO_IDX_MODE      10'h022
// Status register bits
`define FEVRO_ST_COMMAND_COMPLETE_FLAG       7
`define FEVRO_ST_ACCESS_ERROR_FLAG     5
`define FEVRO_ST_PROTECTION_VIOLATION_FLAG     4
`define FEVRO_ST_MG1        1
`define FEVRO_ST_MG0        0
// Command codes
`define FEVRO_CMD_EVSEC     8'h03
`define FEVRO_CMD_RDONCE    8'h04
`define FEVRO_IX_EVSEC      3'h2
`define FEVRO_IX_RDONCE     3'h1
// Program flash window and read-once field
`define FEVRO_PF_LO         24'hff_c000
`define FEVRO_PF_END        25'h100_0000
`define FEVRO_RO_PHRASES    4'h8
// Configuration field addresses
`define FEVRO_CFG_BDKEY     24'hff_fe00
`define FEVRO_CFG_BDKEY_END 24'hff_fe07
`define FEVRO_CFG_OVKEY     24'hff_fe08
`define FEVRO_CFG_RSVD      24'hff_fe0a
`define FEVRO_CFG_PROGRAM_PROTECTION_BYTE     24'hff_fe0c
`define FEVRO_CFG_EEPROM_PROTECTION_BYTE    24'hff_fe0d
`define FEVRO_CFG_NONVOLATILE_OPTION_BYTE      24'hff_fe0e
`define FEVRO_CFG_SECURITY_BYTE      24'hff_fe0f
`define FEVRO_CFG_RSVD_VAL  8'hff
`define FEVRO_AV_ADDR_W     10
`endif

// ### logic/fevro_pkg.sv
// Purpose: Types of the flash sequencer.
// Assumes: Used by fully qualified names only.
// Notes:   States Gray coded along the usual path.
package fevro_pkg;
  // Sequencer states
  typedef enum logic [1:0]
  {
    FEVRO_IDLE  = 2'b00,
    FEVRO_CHECK = 2'b01,
    FEVRO_RUN   = 2'b11,
    FEVRO_DONE  = 2'b10
  } fevro_state_t;
endpackage

// ### logic/fevro_seq.sv
// Purpose: Erase verify and read once command sequencer, Avalon slave.
// Assumes: Flash array is read through a one-cycle-latency phrase port.
// Notes:   Every access answers after one wait cycle.
`timescale 1ns/1ps
`include "fevro_regs.svh"
module fevro_seq
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic      [23:0] fl_addr,
  output logic             fl_rd,
  output logic             fl_ro_sel,
  input  wire logic [63:0] fl_data,
  input  wire logic        fl_err_cor,
  input  wire logic        fl_err_unc,
  output logic             irq
);
  // Flash inputs come from the array on this clock, no synchroniser
  fevro_pkg::fevro_state_t state_reg;
  logic [2:0]  ix_reg;           // Command object index
  logic [15:0] obj_reg [0:5];    // Command object words
  logic        command_complete_flag_reg;         // Command complete
  logic        access_error_flag_reg;       // Access error
  logic        mg1_reg;          // Status bit high
  logic        mg0_reg;          // Status bit low
  logic [1:0]  mode_reg;         // Operating mode, 0 allows all
  logic [1:0]  irq_stat_reg;     // Sticky: done, error
  logic [1:0]  irq_mask_reg;     // Interrupt mask
  logic        ack_reg;          // Single wait cycle per access
  logic [24:0] cur_reg;          // Current verify address
  logic [15:0] left_reg;         // Phrases left
  logic        rd_pend_reg;      // Flash read outstanding
  logic [31:0] rdata_next;
  logic        wr_ok;
  logic        launch;
  logic        bad;
  logic        done_ev;
  logic        is_ev;
  logic        is_ro;
  logic [24:0] start_a;
  logic [24:0] end_a;
  wire  [7:0]  wb = avs_writedata[7:0];

  // Bus handshake
  // Accept exactly one bus cycle after a request, then release
  // One fixed wait cycle keeps read data registered and timing simple;
  // the cost is two cycles per access even for plain register reads
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
  end
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_ok = avs_write & ack_reg & avs_byteenable[0];

  // Launch: write one to the completion bit clears it
  // launch on clear
  assign launch = wr_ok && avs_address == `FEVRO_IDX_STAT
                  && wb[`FEVRO_ST_COMMAND_COMPLETE_FLAG] && command_complete_flag_reg;

  // Command decode and parameter check
  // All checks run in one cycle on the loaded object words, so the
  // access error is known before any flash read is issued
  // Unknown command codes are refused like a bad parameter
  assign is_ev   = obj_reg[0][15:8] == `FEVRO_CMD_EVSEC;
  assign is_ro   = obj_reg[0][15:8] == `FEVRO_CMD_RDONCE;
  assign start_a = {1'b0, obj_reg[0][7:0], obj_reg[1]};
  assign end_a   = start_a + {6'h00, obj_reg[2], 3'h0};
  always_comb
  begin
    bad = 1'b0;
    if (is_ev)
    begin
      if (ix_reg != `FEVRO_IX_EVSEC) bad = 1'b1;
      if (mode_reg != 2'h0) bad = 1'b1;
      if (start_a < {1'b0, `FEVRO_PF_LO}) bad = 1'b1;
      if (start_a[2:0] != 3'h0) bad = 1'b1;
      if (end_a > `FEVRO_PF_END) bad = 1'b1;
    end
    else if (is_ro)
    begin
      if (ix_reg != `FEVRO_IX_RDONCE) bad = 1'b1;
      if (obj_reg[1] >= {12'h000, `FEVRO_RO_PHRASES}) bad = 1'b1;
    end
    else
      bad = 1'b1;
  end

  // Sequencer
  // Idle waits for a launch, check latches the start point, run walks
  // the phrases, done lasts one cycle and raises the completion flag
  // A refused command goes straight from check to done
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg   <= fevro_pkg::FEVRO_IDLE;
      cur_reg     <= 25'h0;
      left_reg    <= 16'h0;
      rd_pend_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        fevro_pkg::FEVRO_IDLE:
          if (launch)
            state_reg <= fevro_pkg::FEVRO_CHECK;
        fevro_pkg::FEVRO_CHECK:
        begin
          cur_reg     <= start_a;
          left_reg    <= is_ro ? 16'h1 : obj_reg[2];
          rd_pend_reg <= 1'b0;
          state_reg   <= bad ? fevro_pkg::FEVRO_DONE
                             : fevro_pkg::FEVRO_RUN;
        end
        fevro_pkg::FEVRO_RUN:
        begin
          // One phrase per two cycles: issue, then check
          if (left_reg == 16'h0)
            state_reg <= fevro_pkg::FEVRO_DONE;
          else if (!rd_pend_reg)
            rd_pend_reg <= 1'b1;
          else
          begin
            rd_pend_reg <= 1'b0;
            left_reg    <= left_reg - 16'h1;
            cur_reg     <= cur_reg + 25'h8;
          end
        end
        fevro_pkg::FEVRO_DONE:
          state_reg <= fevro_pkg::FEVRO_IDLE;
      endcase
    end
  end
  assign done_ev = state_reg == fevro_pkg::FEVRO_DONE;

  // Flash read port
  // read once selects the 8-phrase info field
  assign fl_rd     = state_reg == fevro_pkg::FEVRO_RUN && left_reg != 16'h0
                     && !rd_pend_reg;
  assign fl_ro_sel = is_ro;
  assign fl_addr   = is_ro ? {18'h0, obj_reg[1][2:0], 3'h0} : cur_reg[23:0];

  // Status flags
  // Launch clears the status bits so each command reports afresh;
  // the access error stays until software writes one to it
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      command_complete_flag_reg   <= 1'b1;
      access_error_flag_reg <= 1'b0;
      mg1_reg    <= 1'b0;
      mg0_reg    <= 1'b0;
    end
    else if (launch)
    begin
      command_complete_flag_reg <= 1'b0;
      mg1_reg  <= 1'b0;
      mg0_reg  <= 1'b0;
    end
    else
    begin
      if (done_ev)
        command_complete_flag_reg <= 1'b1;
      if (state_reg == fevro_pkg::FEVRO_CHECK && bad)
        access_error_flag_reg <= 1'b1;
      else if (wr_ok && avs_address == `FEVRO_IDX_STAT
               && wb[`FEVRO_ST_ACCESS_ERROR_FLAG])
        access_error_flag_reg <= 1'b0;
      if (state_reg == fevro_pkg::FEVRO_RUN && rd_pend_reg && is_ev)
      begin
        if (fl_err_cor || fl_err_unc || fl_data != 64'hffff_ffff_ffff_ffff)
          mg1_reg <= 1'b1;
        if (fl_err_unc || fl_data != 64'hffff_ffff_ffff_ffff)
          mg0_reg <= 1'b1;
      end
      else if (state_reg == fevro_pkg::FEVRO_RUN && rd_pend_reg)
      begin
        if (fl_err_cor || fl_err_unc) mg1_reg <= 1'b1;
        if (fl_err_unc) mg0_reg <= 1'b1;
      end
    end
  end

  // Command object registers and index
  // Writes are dropped while busy so a running command keeps its
  // parameters even if software misbehaves
  // object words hold code, address, count
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ix_reg   <= 3'h0;
      mode_reg <= 2'h0;
      for (int i = 0; i < 6; i++)
        obj_reg[i] <= 16'h0;
    end
    else
    begin
      if (wr_ok && command_complete_flag_reg)
      begin
        if (avs_address == `FEVRO_IDX_COMMAND_OBJECT_INDEX) ix_reg <= wb[2:0];
        if (avs_address == `FEVRO_IDX_MODE) mode_reg <= wb[1:0];
        unique case (avs_address)
          `FEVRO_IDX_CCOB0_HI: obj_reg[0][15:8] <= wb;
          `FEVRO_IDX_CCOB0_LO: obj_reg[0][7:0]  <= wb;
          `FEVRO_IDX_CCOB1_HI: obj_reg[1][15:8] <= wb;
          `FEVRO_IDX_CCOB1_LO: obj_reg[1][7:0]  <= wb;
          `FEVRO_IDX_CCOB2_HI: obj_reg[2][15:8] <= wb;
          `FEVRO_IDX_CCOB2_LO: obj_reg[2][7:0]  <= wb;
          `FEVRO_IDX_CCOB3_HI: obj_reg[3][15:8] <= wb;
          `FEVRO_IDX_CCOB3_LO: obj_reg[3][7:0]  <= wb;
          `FEVRO_IDX_CCOB4_HI: obj_reg[4][15:8] <= wb;
          `FEVRO_IDX_CCOB4_LO: obj_reg[4][7:0]  <= wb;
          `FEVRO_IDX_CCOB5_HI: obj_reg[5][15:8] <= wb;
          `FEVRO_IDX_CCOB5_LO: obj_reg[5][7:0]  <= wb;
          default: ;
        endcase
      end
      // return first word of phrase in word 2
      if (state_reg == fevro_pkg::FEVRO_RUN && rd_pend_reg && is_ro)
        obj_reg[2] <= fl_data[63:48];
    end
  end

  // Interrupt status: set wins over write-one clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
    end
    else
    begin
      irq_stat_reg[0] <= done_ev | (irq_stat_reg[0] & ~(wr_ok
                         && avs_address == `FEVRO_IDX_IRQ_STAT && wb[0]));
      irq_stat_reg[1] <= (done_ev & access_error_flag_reg) | (irq_stat_reg[1] &
                         ~(wr_ok && avs_address == `FEVRO_IDX_IRQ_STAT
                         && wb[1]));
      if (wr_ok && avs_address == `FEVRO_IDX_IRQ_MASK)
        irq_mask_reg <= wb[1:0];
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read mux; unmapped reads return zero
  always_comb
  begin
    rdata_next = 32'h0;
    unique case (avs_address)
      `FEVRO_IDX_STAT:     rdata_next[7:0] = {command_complete_flag_reg, 1'b0, access_error_flag_reg,
                                              3'h0, mg1_reg, mg0_reg};
      `FEVRO_IDX_COMMAND_OBJECT_INDEX:   rdata_next[2:0] = ix_reg;
      `FEVRO_IDX_MODE:     rdata_next[1:0] = mode_reg;
      `FEVRO_IDX_IRQ_STAT: rdata_next[1:0] = irq_stat_reg;
      `FEVRO_IDX_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
      `FEVRO_IDX_CCOB0_HI: rdata_next[7:0] = obj_reg[0][15:8];
      `FEVRO_IDX_CCOB0_LO: rdata_next[7:0] = obj_reg[0][7:0];
      `FEVRO_IDX_CCOB1_HI: rdata_next[7:0] = obj_reg[1][15:8];
      `FEVRO_IDX_CCOB1_LO: rdata_next[7:0] = obj_reg[1][7:0];
      `FEVRO_IDX_CCOB2_HI: rdata_next[7:0] = obj_reg[2][15:8];
      `FEVRO_IDX_CCOB2_LO: rdata_next[7:0] = obj_reg[2][7:0];
      `FEVRO_IDX_CCOB3_HI: rdata_next[7:0] = obj_reg[3][15:8];
      `FEVRO_IDX_CCOB3_LO: rdata_next[7:0] = obj_reg[3][7:0];
      `FEVRO_IDX_CCOB4_HI: rdata_next[7:0] = obj_reg[4][15:8];
      `FEVRO_IDX_CCOB4_LO: rdata_next[7:0] = obj_reg[4][7:0];
      `FEVRO_IDX_CCOB5_HI: rdata_next[7:0] = obj_reg[5][15:8];
      `FEVRO_IDX_CCOB5_LO: rdata_next[7:0] = obj_reg[5][7:0];
      default: rdata_next = 32'h0;
    endcase
  end

  // Read data registered during the wait cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0;
    else
      avs_readdata <= rdata_next;
  end

  // key field bounds kept in constants; no extra logic needed
  // option bytes located by constants
  // Assertions
  a_launch_clears: assert property (@(posedge clk) disable iff (rst)
    launch |=> !command_complete_flag_reg) else $error("launch did not clear flag");
  a_done_sets: assert property (@(posedge clk) disable iff (rst)
    done_ev |=> command_complete_flag_reg) else $error("done did not set flag");
  a_busy_ignored: assert property (@(posedge clk) disable iff (rst)
    wr_ok && !command_complete_flag_reg && is_ev && avs_address == `FEVRO_IDX_CCOB2_LO
    |=> $stable(obj_reg[2][7:0])) else $error("object write while busy");
  a_bad_index: assert property (@(posedge clk) disable iff (rst)
    state_reg == fevro_pkg::FEVRO_CHECK && is_ev && ix_reg != 3'h2
    |=> access_error_flag_reg && state_reg == fevro_pkg::FEVRO_DONE)
    else $error("index error not flagged");
  a_unaligned: assert property (@(posedge clk) disable iff (rst)
    state_reg == fevro_pkg::FEVRO_CHECK && is_ev && start_a[2:0] != 3'h0
    |=> access_error_flag_reg) else $error("misalignment not flagged");
  a_mode_err: assert property (@(posedge clk) disable iff (rst)
    state_reg == fevro_pkg::FEVRO_CHECK && is_ev && mode_reg != 2'h0
    |=> access_error_flag_reg) else $error("mode error not flagged");
  a_mg0_implies: assert property (@(posedge clk) disable iff (rst)
    $rose(mg0_reg) |-> mg1_reg) else $error("low bit without high");
  a_blank_fail: assert property (@(posedge clk) disable iff (rst)
    state_reg == fevro_pkg::FEVRO_RUN && rd_pend_reg && is_ev
    && fl_data != 64'hffff_ffff_ffff_ffff |=> mg1_reg && mg0_reg)
    else $error("blank fail not flagged");
  a_cor_only: assert property (@(posedge clk) disable iff (rst)
    state_reg == fevro_pkg::FEVRO_RUN && rd_pend_reg && fl_err_cor
    |=> mg1_reg) else $error("read error not flagged");
  a_wait_one: assert property (@(posedge clk) disable iff (rst)
    avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  c_ev_run: cover property (@(posedge clk) disable iff (rst)
    state_reg == fevro_pkg::FEVRO_RUN && is_ev);
  c_ro_run: cover property (@(posedge clk) disable iff (rst)
    state_reg == fevro_pkg::FEVRO_RUN && is_ro);
  c_err: cover property (@(posedge clk) disable iff (rst) $rose(access_error_flag_reg));
  c_irq: cover property (@(posedge clk) disable iff (rst) $rose(irq));
endmodule // fevro_seq

// ### dv/fevro_seq_tb_top.sv
// Purpose: Self-checking bench of the erase verify / read once sequencer.
// Assumes: Erased flash reads all ones; the bench answers the flash port.
// Notes:   Registers reached by Avalon word index; one idle cycle between.
`timescale 1ns/1ps
`include "fevro_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module fevro_seq_tb_top;
  logic        clk            = 1'b0;
  logic        rst            = 1'b1;
  logic [9:0]  avs_address    = '0;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = '0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [23:0] fl_addr;
  logic        fl_rd;
  logic        fl_ro_sel;
  logic [63:0] fl_data        = '0;
  logic        fl_err_cor     = 1'b0;
  logic        fl_err_unc     = 1'b0;
  logic        irq;
  int          failures       = 0;
  int          n_checks       = 0;
  int          cyc            = 0;
  int          n_rd           = 0;
  logic [23:0] exp_a          = '0;  // Next phrase address expected
  logic        ro_exp         = 1'b0;
  logic        rd_q           = 1'b0;
  logic [63:0] flash_word     = '1;  // Array contents seen by the sequencer
  logic        cor_en         = 1'b0;
  logic        unc_en         = 1'b0;
  // Error table: index, word 0, word 1, count, status, reads
  localparam logic [2:0]  E_IX [7] = '{1, 2, 2, 2, 2, 2, 2};
  localparam logic [15:0] E_W0 [7] = '{16'h03ff, 16'h03fe, 16'h03ff,
    16'h03ff, 16'h03ff, 16'h03ff, 16'h05ff};
  localparam logic [15:0] E_W1 [7] = '{16'hc000, 16'hc000, 16'h8000,
    16'hc004, 16'hfff8, 16'hfff8, 16'hc000};
  localparam logic [15:0] E_W2 [7] = '{1, 1, 1, 1, 2, 1, 1};
  localparam logic [7:0]  E_ST [7] = '{8'ha0, 8'ha0, 8'ha0, 8'ha0, 8'ha0,
    8'h80, 8'ha0};
  localparam int          E_N  [7] = '{0, 0, 0, 0, 0, 1, 0};
  localparam logic [7:0]  MG_EXP [4] = '{8'h80, 8'h83, 8'h82, 8'h83};

  fevro_seq i_fevro_seq (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fl_addr(fl_addr), .fl_rd(fl_rd), .fl_ro_sel(fl_ro_sel),
    .fl_data(fl_data), .fl_err_cor(fl_err_cor), .fl_err_unc(fl_err_unc),
    .irq(irq));

  always #25 clk = ~clk;

  // Watch reads mid-cycle, where the combinational strobe has settled
  always @(negedge clk)
  begin
    rd_q = fl_rd;
    if (fl_rd === 1'b1)
    begin
      `CHK(fl_addr, exp_a)
      `CHK(fl_ro_sel, ro_exp)
      exp_a = exp_a + 24'h8;
      n_rd++;
    end
  end

  // Flash answers one cycle after the strobe; otherwise shows garbage
  always @(posedge clk)
  begin
    fl_data <= rd_q ? flash_word : ~flash_word;
    fl_err_cor <= rd_q & cor_en;
    fl_err_unc <= rd_q & unc_en;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic test_done;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One Avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    int t;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    t = 0;
    // Sample on the rising edge; data is taken where waitrequest is low
    do
    begin
      @(posedge clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    if (avs_waitrequest !== 1'b0)
      failures++;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] q);
    bus(1'b0, a, 8'h00, q);
  endtask

  // Load the object words and launch by writing one to the flag
  task automatic launch(input logic [2:0] ix, input logic [15:0] w0, w1,
                        w2, input logic [23:0] a0, input logic ro);
    n_rd = 0;
    exp_a = a0;
    ro_exp = ro;
    wr(`FEVRO_IDX_COMMAND_OBJECT_INDEX, {5'h0, ix});
    wr(`FEVRO_IDX_CCOB0_HI, w0[15:8]);
    wr(`FEVRO_IDX_CCOB0_LO, w0[7:0]);
    wr(`FEVRO_IDX_CCOB1_HI, w1[15:8]);
    wr(`FEVRO_IDX_CCOB1_LO, w1[7:0]);
    wr(`FEVRO_IDX_CCOB2_HI, w2[15:8]);
    wr(`FEVRO_IDX_CCOB2_LO, w2[7:0]);
    wr(`FEVRO_IDX_STAT, 8'h80);
  endtask

  // Poll for completion, then clear a sticky access error
  task automatic finish(output logic [7:0] st);
    int t;
    logic [7:0] q;
    t = 0;
    do
    begin
      rd(`FEVRO_IDX_STAT, q);
      t++;
    end while (q[7] !== 1'b1 && t < 200);
    st = q & 8'hb3;
    wr(`FEVRO_IDX_STAT, 8'h20);
  endtask

  task automatic t_reset;
    logic [7:0] q;
    rd(`FEVRO_IDX_STAT, q);
    `CHK(q & 8'hb3, 8'h80)
    `CHK(irq, 1'b0)
    wr(`FEVRO_IDX_CCOB5_HI, 8'ha5);
    wr(`FEVRO_IDX_CCOB5_LO, 8'h5a);
    rd(`FEVRO_IDX_CCOB5_HI, q);
    `CHK(q, 8'ha5)
    rd(`FEVRO_IDX_CCOB5_LO, q);
    `CHK(q, 8'h5a)
    rd(10'h3ff, q);
    `CHK(q, 8'h00)
  endtask

  // Blank, not blank, correctable and uncorrectable reads
  task automatic t_verify;
    logic [7:0] st;
    for (int i = 0; i < 4; i++)
    begin
      flash_word = (i == 1) ? 64'hffff_ffff_ffff_fffe : '1;
      cor_en = (i == 2);
      unc_en = (i == 3);
      launch(3'h2, 16'h03ff, 16'hc010, 16'h0003, 24'hffc010, 1'b0);
      finish(st);
      `CHK(st, MG_EXP[i])
      `CHK(n_rd, 3)
    end
    flash_word = '1;
    cor_en = 1'b0;
    unc_en = 1'b0;
  endtask

  // Launch refusals, and the last phrase before the boundary, which is accepted
  task automatic t_errors;
    logic [7:0] st;
    for (int i = 0; i < 7; i++)
    begin
      launch(E_IX[i], E_W0[i], E_W1[i], E_W2[i], {E_W0[i][7:0], E_W1[i]},
             1'b0);
      finish(st);
      `CHK(st, E_ST[i])
      `CHK(n_rd, E_N[i])
    end
    wr(`FEVRO_IDX_MODE, 8'h01);
    launch(3'h2, 16'h03ff, 16'hc000, 16'h0001, 24'hffc000, 1'b0);
    finish(st);
    `CHK(st, 8'ha0)
    `CHK(n_rd, 0)
    wr(`FEVRO_IDX_MODE, 8'h00);
  endtask

  // A second launch and an object write while busy both go nowhere
  task automatic t_busy;
    logic [7:0] q;
    launch(3'h2, 16'h03ff, 16'hc000, 16'h0040, 24'hffc000, 1'b0);
    rd(`FEVRO_IDX_STAT, q);
    `CHK(q[7], 1'b0)
    wr(`FEVRO_IDX_CCOB2_LO, 8'h01);
    wr(`FEVRO_IDX_STAT, 8'h80);
    finish(q);
    `CHK(q, 8'h80)
    `CHK(n_rd, 64)
    rd(`FEVRO_IDX_CCOB2_LO, q);
    `CHK(q, 8'h40)
  endtask

  // reserved bytes untouched
  // Every read-once phrase, then an index past the field
  task automatic t_read_once;
    logic [7:0] q;
    for (int i = 0; i < 9; i++)
    begin
      flash_word = {8'hc0 + 8'(i), 8'h3c, 48'h0123_4567_89ab};
      launch(3'h1, 16'h0400, 16'(i), 16'h0000, 24'(i * 8), 1'b1);
      finish(q);
      `CHK(q, (i < 8) ? 8'h80 : 8'ha0)
      `CHK(n_rd, (i < 8) ? 1 : 0)
      if (i < 8)
      begin
        rd(`FEVRO_IDX_CCOB2_HI, q);
        `CHK(q, 8'hc0 + 8'(i))
        rd(`FEVRO_IDX_CCOB2_LO, q);
        `CHK(q, 8'h3c)
      end
    end
    flash_word = '1;
  endtask

  // Completion events, mask, clear by writing ones
  task automatic t_irq;
    logic [7:0] q;
    logic       a;
    logic       b;
    wr(`FEVRO_IDX_IRQ_STAT, 8'h03);
    launch(3'h2, 16'h03ff, 16'hc000, 16'h0001, 24'hffc000, 1'b0);
    finish(q);
    rd(`FEVRO_IDX_IRQ_STAT, q);
    `CHK(q[0], 1'b1)
    wr(`FEVRO_IDX_IRQ_MASK, 8'h00);
    @(negedge clk);
    a = irq;
    wr(`FEVRO_IDX_IRQ_MASK, 8'h03);
    @(negedge clk);
    b = irq;
    `CHK(a, 1'b0)
    `CHK(b, 1'b1)
    wr(`FEVRO_IDX_IRQ_STAT, 8'h03);
    @(negedge clk);
    `CHK(irq, 1'b0)
    launch(3'h1, 16'h03ff, 16'hc000, 16'h0001, 24'hffc000, 1'b0);
    finish(q);
    rd(`FEVRO_IDX_IRQ_STAT, q);
    `CHK(q[1], 1'b1)
  endtask

  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_verify();
    t_errors();
    t_busy();
    t_read_once();
    t_irq();
    test_done();
  end
endmodule // fevro_seq_tb_top
